// file: tb/afsp_host.sv
// afsp_host: host side of the port, frame syncs and external clock
// assumes core_clk at 125 MHz; link half period of 4 core cycles
`timescale 1ns/1ps
module afsp_host
(
   input wire logic core_clk,
   input wire logic serial_clk_o,
   input wire logic serial_clk_oe,
   input wire logic serial_data_o,
   input wire logic serial_data_oe,
   output logic read_frame_sync_n,
   output logic write_frame_sync_n,
   output logic register_select,
   output logic serial_clk_i,
   output logic serial_data_i
);
   logic hclk = 1'b1;
   logic hbit = 1'b0;
   logic hdrv = 1'b0;
   logic drv_seen = 1'b0;
   initial
   begin
      read_frame_sync_n = 1'b1;
      write_frame_sync_n = 1'b1;
      register_select = 1'b0;
   end
   assign serial_clk_i = serial_clk_oe ? serial_clk_o : hclk;
   assign serial_data_i = serial_data_oe ? serial_data_o : hbit;
   // released line toggles
   always @(posedge core_clk)
   begin
      if (!hdrv)
         hbit <= ~hbit;
      if (serial_data_oe)
         drv_seen <= 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // one frame of n clock pulses, msb first
   task automatic xfer(input bit rd, input bit sel, input int n,
      input logic [23:0] w, output logic [23:0] r);
      r = '0;
      cyc(1);
      drv_seen = 1'b0;
      register_select = sel;
      hdrv = !rd;
      if (rd)
         read_frame_sync_n = 1'b0;
      else
         write_frame_sync_n = 1'b0;
      cyc(6);
      for (int i = 0; i < n; i++)
      begin
         hclk = 1'b0;
         if (!rd)
            hbit = (i < 24) ? w[23 - i] : ~hbit;
         cyc(4);
         r = {r[22:0], serial_data_i};
         hclk = 1'b1;
         cyc(4);
      end
      cyc(4);
      read_frame_sync_n = 1'b1;
      write_frame_sync_n = 1'b1;
      cyc(6);
      hdrv = 1'b0;
   endtask
endmodule // afsp_host

// file: tb/afsp_port_tb.sv
// afsp_port_tb: self-checking bench for the framed serial port
// assumes afsp_host as the far side; external clocking unless noted
`timescale 1ns/1ps
module afsp_port_tb;
   import afsp_pkg::*;
   logic core_clk, sys_rst, self_clock_mode, rfs_n, tfs_n, sel;
   logic sclk_i, sclk_o, sclk_oe, sd_i, sd_o, sd_oe, result_ready_n;
   logic signed [23:0] result_raw;
   logic result_valid, cal_done, cal_wr_strobe, pv;
   logic [23:0] cal_wr_data, control_config_word, r;
   logic [23:0] cfg [4] = '{24'h001000, 24'h001000, 24'h0, 24'h0};
   logic [23:0] raw [4] = '{24'h123456, 24'hff0000, 24'hff0000, 24'h1};
   logic [23:0] exp [4] = '{24'h2468ac, 24'h0, 24'h7f0000, 24'h800001};
   int n_fail = 0;
   int cmp_count = 0;
   int n;
   int n_strobe = 0;
   afsp_port i_afsp_port (.core_clk(core_clk), .sys_rst(sys_rst),
      .self_clock_mode(self_clock_mode), .read_frame_sync_n(rfs_n),
      .write_frame_sync_n(tfs_n), .register_select(sel),
      .serial_clk_i(sclk_i), .serial_clk_o(sclk_o),
      .serial_clk_oe(sclk_oe), .serial_data_i(sd_i),
      .serial_data_o(sd_o), .serial_data_oe(sd_oe),
      .result_ready_n(result_ready_n), .result_raw(result_raw),
      .result_valid(result_valid), .cal_done(cal_done),
      .cal_rd_data(24'h5a5a5a), .cal_wr_data(cal_wr_data),
      .cal_wr_strobe(cal_wr_strobe),
      .control_config_word(control_config_word));
   afsp_host i_afsp_host (.core_clk(core_clk), .serial_clk_o(sclk_o),
      .serial_clk_oe(sclk_oe), .serial_data_o(sd_o),
      .serial_data_oe(sd_oe), .read_frame_sync_n(rfs_n),
      .write_frame_sync_n(tfs_n), .register_select(sel),
      .serial_clk_i(sclk_i), .serial_data_i(sd_i));
   // count coefficient strobes, each stands one cycle
   always @(posedge core_clk)
   begin
      if (cal_wr_strobe)
         n_strobe <= n_strobe + 1;
   end
   task automatic chk(input string nm, input logic [23:0] e,
      input logic [23:0] s);
      cmp_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // frame through the host, then line must be released
   task automatic xf(input bit rd, input bit s, input int k,
      input logic [23:0] w);
      i_afsp_host.xfer(rd, s, k, w, r);
      chk("data oe idle", 24'h0, 24'(sd_oe));
   endtask
   task automatic pulse(input bit cal, input logic [23:0] v);
      @(posedge core_clk) #1;
      result_raw = v;
      result_valid = !cal;
      cal_done = cal;
      @(posedge core_clk) #1;
      result_valid = 1'b0;
      cal_done = 1'b0;
      @(posedge core_clk) #1;
   endtask
   // self-clocked control frame: device makes the clock, bench is host
   task automatic self_xf(input bit rd, input logic [23:0] w);
      logic p;
      n = 0;
      r = '0;
      i_afsp_host.register_select = 1'b0;
      i_afsp_host.hdrv = !rd;
      i_afsp_host.hbit = w[23];
      if (rd)
         i_afsp_host.read_frame_sync_n = 1'b0;
      else
         i_afsp_host.write_frame_sync_n = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      chk("self oe", 24'h1, 24'(sclk_oe));
      for (int t = 0; t < 2000 && n < 24; t++)
      begin
         p = sclk_o;
         @(posedge core_clk) #1;
         if (sclk_o && !p)
         begin
            r = {r[22:0], sd_i};
            n++;
         end
         if (!sclk_o && p && n < 24)
            i_afsp_host.hbit = w[23 - n];
      end
      chk("self edges", 24'h18, 24'(n));
      i_afsp_host.read_frame_sync_n = 1'b1;
      i_afsp_host.write_frame_sync_n = 1'b1;
      repeat (8) @(posedge core_clk);
      #1;
      i_afsp_host.hdrv = 1'b0;
      chk("self release", 24'h0, 24'(sclk_oe | sd_oe));
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial
   begin
      #200000;
      n_fail++;
      wrap_up();
   end
   initial
   begin
      sys_rst = 1'b1;
      self_clock_mode = 1'b0;
      result_raw = '0;
      result_valid = 1'b0;
      cal_done = 1'b0;
      repeat (8) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      chk("ready idle", 24'h1, 24'(result_ready_n));
      chk("ctrl reset", CTRL_RESET, control_config_word);
      xf(0, 0, 24, 24'h005a3c);
      chk("ctrl wr", 24'h005a3c, control_config_word);
      xf(1, 0, 24, 24'h0);
      chk("ctrl rd", 24'h005a3c, r);
      xf(0, 0, 12, 24'hfff000);
      chk("short wr", 24'h005a3c, control_config_word);
      xf(0, 0, 30, 24'h00a1b2);
      chk("long wr", 24'h00a1b2, control_config_word);
      $display("test control done");
      for (int k = 0; k < 4; k++)
      begin
         xf(0, 0, 24, cfg[k]);
         pulse(1'b0, raw[k]);
         chk("ready set", 24'h0, 24'(result_ready_n));
         xf(1, 1, 24, 24'h0);
         chk("result", exp[k], r);
         chk("result drv", 24'h1, 24'(i_afsp_host.drv_seen));
         chk("ready clr", 24'h1, 24'(result_ready_n));
      end
      xf(1, 1, 24, 24'h0);
      chk("no ready drv", 24'h0, 24'(i_afsp_host.drv_seen));
      $display("test results done");
      xf(0, 0, 24, 24'h201000);
      pulse(1'b1, 24'h0);
      chk("cal ready", 24'h0, 24'(result_ready_n));
      chk("cal mode", 24'h001000, control_config_word);
      $display("test calibration done");
      xf(0, 0, 24, 24'hc01000);
      xf(0, 1, 24, 24'h3c3c3c);
      chk("coef strobes", 24'h1, 24'(n_strobe));
      chk("coef wr", 24'h3c3c3c, cal_wr_data);
      chk("coef ctrl", 24'hc01000, control_config_word);
      xf(1, 1, 24, 24'h0);
      chk("coef rd", 24'h5a5a5a, r);
      $display("test coefficients done");
      self_clock_mode = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      chk("self oe idle", 24'h0, 24'(sclk_oe));
      self_xf(0, 24'h00c3a5);
      chk("self wr", 24'h00c3a5, control_config_word);
      self_xf(1, 24'h0);
      chk("self rd", 24'h00c3a5, r);
      $display("test self clock done");
      wrap_up();
   end
endmodule // afsp_port_tb

// file: verilog/afsp_pkg.sv
// afsp_pkg: constants for the framed serial port of the converter
// assumes a 125 MHz core clock and a 24-bit control word
package afsp_pkg;
   localparam int WORD_BITS = 24;
   localparam logic [4:0] WORD_LAST = 5'h17;
   localparam logic [4:0] WORD_FULL = 5'h18;
   // control word fields
   localparam int CTRL_MODE_HI = 23;
   localparam int CTRL_MODE_LO = 21;
   localparam int CTRL_WL_BIT = 15;
   localparam int CTRL_BU_BIT = 12;
   localparam logic [23:0] CTRL_RESET = 24'h000000;
   // operating modes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_SELF_CAL = 3'h1;
   localparam logic [2:0] MODE_SYS_OFS = 3'h4;
   localparam logic [1:0] MODE_COEF_HI = 2'h3;
   // self-clock timing
   localparam int SCLK_HALF_NS = 32;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] SCLK_DIV_LAST = 3'(SCLK_HALF_CYC - 1);
   typedef enum logic [1:0]
   {
      AFSP_IDLE = 2'b00,
      AFSP_READ = 2'b01,
      AFSP_WRITE = 2'b10
   } afsp_state_e;
endpackage

// file: verilog/afsp_port.sv
// afsp_port: framed bidirectional serial port, control word, ready flag
// assumes pins arrive asynchronous and conversion core shares core_clk
//
// Operation
// - self-clocking: drive clock after either sync falls, data only after read sync falls
// - external clocking: drive data only after read sync falls
// - result ready goes low when a new result word arrives
// - result ready returns high after a full result word is shifted out
// - calibration finish also pulls result ready low
// - result read drives data only while sync low and ready low
// - write data sampled on rising serial clock while write sync low
// - unipolar results natural binary, bipolar results offset binary
// - writes go to control or coefficients; reads also return results
// - register select low targets the control word
// - control word changes only after a full 24-bit write or, in its mode field, at calibration finish
// - clock pulses beyond the 24th in a write are ignored
// - write data accepted only after write sync falls
// - self-clocking write clock starts only after write sync falls
// - normal mode read with select high returns the result word
`timescale 1ns/1ps
module afsp_port
   import afsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic self_clock_mode,
   input wire logic read_frame_sync_n,
   input wire logic write_frame_sync_n,
   input wire logic register_select,
   input wire logic serial_clk_i,
   output logic serial_clk_o,
   output logic serial_clk_oe,
   input wire logic serial_data_i,
   output logic serial_data_o,
   output logic serial_data_oe,
   output logic result_ready_n,
   input wire logic signed [23:0] result_raw,
   input wire logic result_valid,
   input wire logic cal_done,
   input wire logic [23:0] cal_rd_data,
   output logic [23:0] cal_wr_data,
   output logic cal_wr_strobe,
   output logic [23:0] control_config_word
);
   import afsp_pkg::*;

   // pin synchronisers: rfs, tfs, sel, sclk, serial_data_io, mode
   logic [5:0] pin_raw;
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic rfs_s, tfs_s, sel_s, sclk_s, sd_s, self_s;

   assign pin_raw = {read_frame_sync_n, write_frame_sync_n,
      register_select, serial_clk_i, serial_data_i, self_clock_mode};

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         sync1_q <= 6'h3e;
         sync2_q <= 6'h3e;
      end
      else
      begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   assign {rfs_s, tfs_s, sel_s, sclk_s, sd_s, self_s} = sync2_q;

   function automatic logic [23:0] code_result(
      input logic signed [23:0] raw, input logic bipolar);
      logic [23:0] res;
      res = 24'h000000;
      if (bipolar)
         res = {~raw[23], raw[22:0]};
      else if (!raw[23])
         res = {raw[22:0], 1'b0};
      return res;
   endfunction

   afsp_state_e state_q, state_d;
   logic [23:0] shift_q, shift_d;
   logic [4:0] cnt_q, cnt_d;
   logic [23:0] ctrl_q, ctrl_d;
   logic ready_q, ready_d;
   logic res_rd_q, res_rd_d;
   logic sel_q, sel_d;
   logic own_q, own_d;
   logic [2:0] div_q, div_d;
   logic lvl_prev_q;
   logic cal_wr_q, cal_wr_d;
   logic [23:0] cal_data_q, cal_data_d;
   logic sclk_lvl, rise, fall, clk_run;
   logic [2:0] mode;

   assign mode = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
   assign sclk_lvl = self_s ? own_q : sclk_s;
   assign rise = sclk_lvl && !lvl_prev_q;
   assign fall = !sclk_lvl && lvl_prev_q;
   // own clock runs only inside a frame and stops after 24 bits
   assign clk_run = self_s && (cnt_q != WORD_FULL) &&
      ((state_q == AFSP_READ && !rfs_s) ||
       (state_q == AFSP_WRITE && !tfs_s));

   always_comb
   begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      ctrl_d = ctrl_q;
      ready_d = ready_q;
      res_rd_d = res_rd_q;
      sel_d = sel_q;
      cal_wr_d = 1'b0;
      cal_data_d = cal_data_q;
      case (state_q)
         AFSP_IDLE:
         begin
            cnt_d = 5'h00;
            if (!rfs_s)
            begin
               state_d = AFSP_READ;
               sel_d = sel_s;
               res_rd_d = sel_s && (mode == MODE_NORMAL);
               if (!sel_s)
                  shift_d = ctrl_q;
               else if (mode == MODE_NORMAL)
                  shift_d = code_result(result_raw,
                     !ctrl_q[CTRL_BU_BIT]);
               else
                  shift_d = cal_rd_data;
            end
            else if (!tfs_s)
            begin
               state_d = AFSP_WRITE;
               sel_d = sel_s;
               res_rd_d = 1'b0;
            end
         end
         AFSP_READ:
         begin
            if (rfs_s)
               state_d = AFSP_IDLE;
            else
            begin
               if (rise && cnt_q != WORD_FULL)
               begin
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q == WORD_LAST && res_rd_q)
                     ready_d = 1'b0;
               end
               if (fall && cnt_q != 5'h00 && cnt_q != WORD_FULL)
                  shift_d = {shift_q[22:0], 1'b0};
            end
         end
         AFSP_WRITE:
         begin
            if (tfs_s)
            begin
               state_d = AFSP_IDLE;
               if (cnt_q == WORD_FULL)
               begin
                  if (!sel_q)
                     ctrl_d = shift_q;
                  else if (mode[2:1] == MODE_COEF_HI)
                  begin
                     cal_wr_d = 1'b1;
                     cal_data_d = shift_q;
                  end
               end
            end
            else if (rise && cnt_q != WORD_FULL)
            begin
               shift_d = {shift_q[22:0], sd_s};
               cnt_d = cnt_q + 5'h01;
            end
         end
         default:
            state_d = AFSP_IDLE;
      endcase
      // calibration modes 1 to 4 all fall back to normal mode when done
      if (cal_done && mode >= MODE_SELF_CAL && mode <= MODE_SYS_OFS &&
         mode != 3'h2 && mode != 3'h3)
         ctrl_d[CTRL_MODE_HI:CTRL_MODE_LO] = MODE_NORMAL;
      else if (cal_done && (mode == 3'h2 || mode == 3'h3))
         ctrl_d[CTRL_MODE_HI:CTRL_MODE_LO] = MODE_NORMAL;
      // a new event wins over the clear at word end
      if (result_valid || cal_done)
         ready_d = 1'b1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_q <= AFSP_IDLE;
         shift_q <= 24'h000000;
         cnt_q <= 5'h00;
         ctrl_q <= CTRL_RESET;
         ready_q <= 1'b0;
         res_rd_q <= 1'b0;
         sel_q <= 1'b0;
         cal_wr_q <= 1'b0;
         cal_data_q <= 24'h000000;
      end
      else
      begin
         state_q <= state_d;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         ctrl_q <= ctrl_d;
         ready_q <= ready_d;
         res_rd_q <= res_rd_d;
         sel_q <= sel_d;
         cal_wr_q <= cal_wr_d;
         cal_data_q <= cal_data_d;
      end
   end

   // self clock divider, idles high
   always_comb
   begin
      own_d = 1'b1;
      div_d = 3'h0;
      if (clk_run)
      begin
         own_d = own_q;
         div_d = div_q + 3'h1;
         if (div_q == SCLK_DIV_LAST)
         begin
            own_d = !own_q;
            div_d = 3'h0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         own_q <= 1'b1;
         div_q <= 3'h0;
         lvl_prev_q <= 1'b1;
      end
      else
      begin
         own_q <= own_d;
         div_q <= div_d;
         lvl_prev_q <= sclk_lvl;
      end
   end

   assign serial_clk_o = own_q;
   assign serial_clk_oe = self_s && state_q != AFSP_IDLE &&
      ((state_q == AFSP_READ && !rfs_s) ||
       (state_q == AFSP_WRITE && !tfs_s));
   assign serial_data_o = shift_q[23];
   assign serial_data_oe = (state_q == AFSP_READ) && !rfs_s &&
      (!res_rd_q || ready_q);
   assign result_ready_n = !ready_q;
   assign cal_wr_data = cal_data_q;
   assign cal_wr_strobe = cal_wr_q;
   assign control_config_word = ctrl_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   ready_set_a: assert property (result_valid |=> !result_ready_n)
      else $error("ready not asserted after new result");
   cal_ready_a: assert property (cal_done |=> !result_ready_n)
      else $error("ready not asserted after calibration");
   word_clear_a: assert property (state_q == AFSP_READ && !rfs_s &&
      res_rd_q && rise && cnt_q == WORD_LAST && !result_valid &&
      !cal_done |=> result_ready_n)
      else $error("ready not released after full word");
   idle_release_a: assert property (rfs_s && tfs_s && state_q ==
      AFSP_IDLE |-> !serial_data_oe && !serial_clk_oe)
      else $error("pins driven outside a frame");
   read_gate_a: assert property (serial_data_oe && res_rd_q |->
      !rfs_s && !result_ready_n)
      else $error("result driven without ready");
   ctrl_load_a: assert property (state_q == AFSP_WRITE && tfs_s &&
      cnt_q == WORD_FULL && !sel_q && !cal_done |=>
      control_config_word == $past(shift_q))
      else $error("control word not loaded after full write");
   short_hold_a: assert property (state_q == AFSP_WRITE &&
      cnt_q != WORD_FULL && !cal_done |=> $stable(control_config_word))
      else $error("control word changed by short write");
   bit_cap_a: assert property (cnt_q <= WORD_FULL)
      else $error("bit count past 24");
   write_sample_a: assert property (state_q == AFSP_WRITE && !tfs_s &&
      rise && cnt_q != WORD_FULL |=> shift_q[0] == $past(sd_s))
      else $error("write bit not sampled");
   clk_gate_a: assert property (serial_clk_oe |-> self_s &&
      (!rfs_s || !tfs_s))
      else $error("clock driven outside a frame");

   write_full_c: cover property (state_q == AFSP_WRITE && tfs_s &&
      cnt_q == WORD_FULL);
   result_read_c: cover property (res_rd_q && rise &&
      cnt_q == WORD_LAST);
   self_read_c: cover property (serial_clk_oe && serial_data_oe);
   cal_write_c: cover property (cal_wr_strobe);
endmodule // afsp_port
